//--- omc_mode_ctrl.sv
// Operating-mode control: boot mode, debug entry, wait, pad overrides
`timescale 1ns/1ns
`default_nettype none
module omc_mode_ctrl
   import omc_pkg::*;
#(
   parameter int unsigned NPINS = 8
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output var  logic                 s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output var  logic                 s_axi_wready,
   output var  logic [1:0]           s_axi_bresp,
   output var  logic                 s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output var  logic                 s_axi_arready,
   output var  logic [31:0]          s_axi_rdata,
   output var  logic [1:0]           s_axi_rresp,
   output var  logic                 s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Mode-select level on the shared debug pin
   input  wire logic                 mode_select_debug_pin,
   // Commands from the background debug controller
   input  wire omc_pkg::omc_cmd_t    cmd,
   output var  omc_pkg::omc_cmd_rsp_t cmd_rsp,
   // CPU side
   input  wire omc_pkg::omc_cpu_ev_t cpu_ev,
   output var  omc_pkg::omc_core_t   core,
   output var  logic [15:0]          vector_addr,
   output var  logic [2:0]           mode_state,
   // Pad controls of the port
   output var  logic [NPINS-1:0]     pad_pull_en,
   output var  logic [NPINS-1:0]     pad_slew_en
);
   omc_state_t       state_q;
   omc_state_t       state_d;
   logic             pin_level;
   logic             boot_bg_q;
   logic [1:0]       ctrl_q;
   logic [NPINS-1:0] pull_q;
   logic [NPINS-1:0] slew_q;
   logic             enter_bg;
   logic             take_cmd;
   logic             bg_cmd;
   logic             resume_cmd;
   logic             trace_cmd;
   logic             wait_like;

   // Classes allowed while the user program runs
   function automatic logic is_nonintrusive(input omc_cmd_class_t c);
      return (c == CMD_MEM) || (c == CMD_MEM_STAT) ||
             (c == CMD_DBG_REG) || (c == CMD_BACKGROUND);
   endfunction : is_nonintrusive

   // Register index decode shared by read and write
   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      unique case (a)
         OFF_CTRL:   reg_sel = 3'h1;
         OFF_PULL:   reg_sel = 3'h2;
         OFF_SLEW:   reg_sel = 3'h3;
         OFF_STATUS: reg_sel = 3'h4;
         default:    reg_sel = 3'h0;
      endcase
   endfunction : reg_sel

   // Address outside the register map
   function automatic logic is_unmapped(input logic [7:0] a);
      return reg_sel(a) == 3'h0;
   endfunction : is_unmapped

   // Settled mode-select level
   omc_sync3 u_sync (
      .aclk  (aclk),
      .pin   (mode_select_debug_pin),
      .level (pin_level)
   );

   // Command decodes and the low-power condition
   assign take_cmd   = cmd.valid;
   assign bg_cmd     = take_cmd && (cmd.cls == CMD_BACKGROUND);
   assign resume_cmd = take_cmd && (cmd.cls == CMD_RESUME);
   assign trace_cmd  = take_cmd && (cmd.cls == CMD_TRACE);
   assign wait_like  = (state_q == ST_WAIT) || cpu_ev.stopped;

   // Entry sources from run mode
   assign enter_bg = bg_cmd
                   || cpu_ev.halt_instr
                   || cpu_ev.bdc_bkpt || cpu_ev.dbg_bkpt;

   // Boot choice caught once, in the first cycle after release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_bg_q <= 1'b0;
      end else if (state_q == ST_HOLD) begin
         boot_bg_q <= ~pin_level;
      end
   end

   // Mode sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_HOLD: begin
            if (pin_level) begin
               state_d = ST_VECTOR;
            end else begin
               state_d = ST_HALT_TO_DEBUG_INSTRUCTION;
            end
         end
         ST_VECTOR: begin
            state_d = ST_RUN;
         end
         ST_RUN: begin
            if (enter_bg) begin
               state_d = ST_HALT_TO_DEBUG_INSTRUCTION;
            end else if (cpu_ev.wait_instr) begin
               state_d = ST_WAIT;
            end
         end
         ST_HALT_TO_DEBUG_INSTRUCTION: begin
            if (resume_cmd) begin
               state_d = ST_RUN;
            end
         end
         ST_WAIT: begin
            if (bg_cmd) begin
               state_d = ST_HALT_TO_DEBUG_INSTRUCTION;
            end else if (cpu_ev.irq_req) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_HOLD;
         end
      endcase
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_HOLD;
      end else begin
         state_q <= state_d;
      end
   end

   // CPU and system controls, registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core        <= '0;
         vector_addr <= '0;
      end else begin
         core.cpu_clk_en  <= (state_d == ST_RUN) || (state_d == ST_VECTOR);
         core.cpu_suspend <= (state_d == ST_HALT_TO_DEBUG_INSTRUCTION);
         core.sys_clk_en  <= 1'b1;
         core.reg_full    <= 1'b1;
         core.imask_clr   <= (state_q == ST_RUN) && (state_d == ST_WAIT);
         core.stack_start <= (state_q == ST_WAIT) && (state_d == ST_RUN);
         core.vec_fetch   <= (state_d == ST_VECTOR);
         core.step        <= (state_q == ST_HALT_TO_DEBUG_INSTRUCTION)
                             && trace_cmd;
         if (state_d == ST_VECTOR) begin
            vector_addr <= RESET_VECTOR_ADDR;
         end
      end
   end

   // Command admission by mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_rsp <= '0;
      end else begin
         cmd_rsp <= '0;
         if (take_cmd) begin
            cmd_rsp.done <= 1'b1;
            if (wait_like) begin
               if (cmd.cls == CMD_MEM_STAT) begin
                  cmd_rsp.mode_err <= 1'b1;
               end else if (cmd.cls == CMD_BACKGROUND) begin
                  cmd_rsp.executed <= 1'b1;
               end else begin
                  cmd_rsp.ignored <= 1'b1;
               end
            end else if (state_q == ST_HALT_TO_DEBUG_INSTRUCTION) begin
               cmd_rsp.executed <= 1'b1;
            end else if ((state_q == ST_RUN) && is_nonintrusive(cmd.cls)) begin
               cmd_rsp.executed <= 1'b1;
            end else begin
               cmd_rsp.ignored <= 1'b1;
            end
         end
      end
   end

   assign mode_state = state_q;

   // AXI4-Lite write channel
   logic       have_aw_q;
   logic       have_w_q;
   logic [7:0] awaddr_q;
   logic [7:0] wdata_q;
   logic       wlane_q;
   logic       do_write;

   assign s_axi_awready = !have_aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !have_w_q && !s_axi_bvalid;
   assign do_write      = have_aw_q && have_w_q && !s_axi_bvalid;

   // Address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         have_aw_q <= 1'b0;
         have_w_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wlane_q   <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            have_aw_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (do_write) begin
            have_aw_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            have_w_q <= 1'b1;
            wdata_q  <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
         end else if (do_write) begin
            have_w_q <= 1'b0;
         end
      end
   end

   // Register writes, low byte lane only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RST;
         pull_q <= PULL_RST[NPINS-1:0];
         slew_q <= SLEW_RST[NPINS-1:0];
      end else if (do_write && wlane_q) begin
         unique case (reg_sel(awaddr_q))
            3'h1: ctrl_q <= wdata_q[1:0];
            3'h2: pull_q <= wdata_q[NPINS-1:0];
            3'h3: slew_q <= wdata_q[NPINS-1:0];
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= is_unmapped(awaddr_q) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // AXI4-Lite read channel
   logic [31:0] rdata_d;

   assign s_axi_arready = !s_axi_rvalid;

   // Read data mux
   always_comb begin
      rdata_d = '0;
      unique case (reg_sel(s_axi_araddr))
         3'h1: rdata_d[1:0] = ctrl_q;
         3'h2: rdata_d[NPINS-1:0] = pull_q;
         3'h3: rdata_d[NPINS-1:0] = slew_q;
         3'h4: begin
            rdata_d[STAT_STATE_LSB +: 3] = state_q;
            rdata_d[STAT_BOOT_BIT]       = boot_bg_q;
            rdata_d[STAT_PIN_BIT]        = pin_level;
            rdata_d[STAT_STOP_BIT]       = cpu_ev.stopped;
         end
         default: rdata_d = '0;
      endcase
   end

   // Read answer one cycle after address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdata_d;
         s_axi_rresp  <= is_unmapped(s_axi_araddr) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Pad overrides for debug and crystal functions
   omc_pad_ctrl #(
      .NPINS (NPINS)
   ) u_pad (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .pull_sw    (pull_q),
      .slew_sw    (slew_q),
      .debug_fn   (ctrl_q[CTRL_DBG_BIT]),
      .crystal_fn (ctrl_q[CTRL_CRYSTAL_OUTPUT_PIN_BIT]),
      .pull_en    (pad_pull_en),
      .slew_en    (pad_slew_en)
   );
endmodule : omc_mode_ctrl
`default_nettype wire

//--- omc_pkg.sv
// Shared constants, states and carriers of the operating-mode control block
`default_nettype none
package omc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_PULL   = 8'h04;
   localparam logic [7:0] OFF_SLEW   = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   // Control fields and reset values
   localparam int unsigned CTRL_DBG_BIT  = 0;
   localparam int unsigned CTRL_CRYSTAL_OUTPUT_PIN_BIT = 1;
   localparam logic [1:0]  CTRL_RST      = 2'h1;
   localparam logic [7:0]  PULL_RST      = 8'h00;
   localparam logic [7:0]  SLEW_RST      = 8'h00;
   localparam logic [7:0]  PAD_PULL_RST  = 8'h01;
   localparam logic [7:0]  PAD_SLEW_RST  = 8'h00;
   // Status fields
   localparam int unsigned STAT_STATE_LSB = 0;
   localparam int unsigned STAT_BOOT_BIT  = 3;
   localparam int unsigned STAT_PIN_BIT   = 4;
   localparam int unsigned STAT_STOP_BIT  = 5;
   // Pin positions inside the port
   localparam int unsigned PIN_DEBUG = 0;
   localparam int unsigned PIN_XOUT  = 1;
   localparam int unsigned PIN_XIN   = 2;
   // Bus answers and the start-address location
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;

   typedef enum logic [2:0] {
      ST_HOLD   = 3'b000,
      ST_VECTOR = 3'b001,
      ST_RUN    = 3'b010,
      ST_HALT_TO_DEBUG_INSTRUCTION   = 3'b011,
      ST_WAIT   = 3'b100
   } omc_state_t;

   typedef enum logic [2:0] {
      CMD_MEM        = 3'b000,
      CMD_MEM_STAT   = 3'b001,
      CMD_DBG_REG    = 3'b010,
      CMD_BACKGROUND = 3'b011,
      CMD_CPU_REG    = 3'b100,
      CMD_TRACE      = 3'b101,
      CMD_RESUME     = 3'b110
   } omc_cmd_class_t;

   // Command from the debug link decoder
   typedef struct packed {
      logic           valid;
      omc_cmd_class_t cls;
   } omc_cmd_t;

   // Answer to one command
   typedef struct packed {
      logic done;
      logic executed;
      logic mode_err;
      logic ignored;
   } omc_cmd_rsp_t;

   // Events from the CPU core
   typedef struct packed {
      logic halt_instr;
      logic bdc_bkpt;
      logic dbg_bkpt;
      logic wait_instr;
      logic irq_req;
      logic stopped;
   } omc_cpu_ev_t;

   // Controls toward the CPU and system
   typedef struct packed {
      logic cpu_clk_en;
      logic cpu_suspend;
      logic sys_clk_en;
      logic reg_full;
      logic imask_clr;
      logic stack_start;
      logic vec_fetch;
      logic step;
   } omc_core_t;
endpackage : omc_pkg
`default_nettype wire

//--- omc_sync3.sv
// Three-stage synchroniser that settles a pin level
`timescale 1ns/1ns
`default_nettype none
module omc_sync3 (
   input  wire logic aclk,
   input  wire logic pin,
   output var  logic level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;

   // Chain runs through reset so the level is valid at release
   always_ff @(posedge aclk) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   // Level moves only when the two later stages agree
   always_ff @(posedge aclk) begin
      if (s2_q == s3_q) begin
         lvl_q <= s3_q;
      end
   end

   assign level = lvl_q;
endmodule : omc_sync3
`default_nettype wire

//--- omc_pad_ctrl.sv
// Pullup and slew controls of one port with function overrides
`timescale 1ns/1ns
`default_nettype none
module omc_pad_ctrl
   import omc_pkg::*;
#(
   parameter int unsigned NPINS = 8
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [NPINS-1:0] pull_sw,
   input  wire logic [NPINS-1:0] slew_sw,
   input  wire logic             debug_fn,
   input  wire logic             crystal_fn,
   output var  logic [NPINS-1:0] pull_en,
   output var  logic [NPINS-1:0] slew_en
);
   logic [NPINS-1:0] pull_d;
   logic [NPINS-1:0] slew_d;

   // Software settings, then pin-function overrides
   always_comb begin
      pull_d = pull_sw;
      slew_d = slew_sw;
      if (crystal_fn) begin
         pull_d[PIN_XOUT] = 1'b0;
         pull_d[PIN_XIN]  = 1'b0;
         slew_d[PIN_XOUT] = 1'b0;
         slew_d[PIN_XIN]  = 1'b0;
      end
      if (debug_fn) begin
         pull_d[PIN_DEBUG] = 1'b1;
         slew_d[PIN_DEBUG] = 1'b0;
      end
   end

   // Registered pad controls
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pull_en <= PAD_PULL_RST[NPINS-1:0];
         slew_en <= PAD_SLEW_RST[NPINS-1:0];
      end else begin
         pull_en <= pull_d;
         slew_en <= slew_d;
      end
   end
endmodule : omc_pad_ctrl
`default_nettype wire

//--- omc_mode_ctrl_sva.sv
// Checker of mode entry, command answers and wait behaviour
`timescale 1ns/1ns
`default_nettype none
module omc_mode_ctrl_sva
   import omc_pkg::*;
(
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire omc_pkg::omc_cmd_t     cmd,
   input wire omc_pkg::omc_cmd_rsp_t cmd_rsp,
   input wire omc_pkg::omc_cpu_ev_t  cpu_ev,
   input wire omc_pkg::omc_core_t    core,
   input wire logic [15:0]           vector_addr,
   input wire logic [2:0]            mode_state
);
   import omc_pkg::*;
   logic run, bgd, wt, bgc, evs;
   // State and request decodes
   assign run = mode_state == ST_RUN;
   assign bgd = mode_state == ST_HALT_TO_DEBUG_INSTRUCTION;
   assign wt  = mode_state == ST_WAIT;
   assign bgc = cmd.valid && cmd.cls == CMD_BACKGROUND;
   assign evs = cpu_ev.halt_instr || cpu_ev.bdc_bkpt || cpu_ev.dbg_bkpt;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   vec_fetch_a: assert property (mode_state == ST_VECTOR |-> core.vec_fetch
      && vector_addr == RESET_VECTOR_ADDR ##1 run && !core.vec_fetch)
      else $error("start vector fetch missing");
   bgd_cmd_a: assert property ((run || wt) && bgc |=> bgd)
      else $error("background command not obeyed");
   halt_enter_a: assert property (run && cpu_ev.halt_instr |=> bgd)
      else $error("halt instruction not obeyed");
   bkpt_enter_a: assert property (run && (cpu_ev.bdc_bkpt || cpu_ev.dbg_bkpt) |=> bgd)
      else $error("breakpoint not obeyed");
   cpu_held_a: assert property (bgd |-> core.cpu_suspend && !core.cpu_clk_en)
      else $error("cpu runs in background");
   nonintr_a: assert property ((run || bgd) && cmd.valid && cmd.cls <= CMD_BACKGROUND
      && !cpu_ev.stopped |=> cmd_rsp.done && cmd_rsp.executed) else $error("command refused");
   active_only_a: assert property (run && cmd.valid && cmd.cls >= CMD_CPU_REG
      |=> cmd_rsp.ignored && !cmd_rsp.executed && !core.step) else $error("run executed cmd");
   trace_step_a: assert property (bgd && cmd.valid && cmd.cls == CMD_TRACE
      |=> core.step && cmd_rsp.executed) else $error("trace step missing");
   resume_a: assert property (bgd && cmd.valid && cmd.cls == CMD_RESUME
      |=> run && core.cpu_clk_en && !core.cpu_suspend) else $error("resume failed");
   wait_in_a: assert property (run && cpu_ev.wait_instr && !evs && !bgc
      |=> wt && core.imask_clr && !core.cpu_clk_en ##1 !core.imask_clr)
      else $error("wait entry wrong");
   wait_clk_a: assert property (wt |-> core.sys_clk_en && core.reg_full)
      else $error("system clock off in wait");
   irq_wake_a: assert property (wt && cpu_ev.irq_req && !bgc |=> run && core.stack_start)
      else $error("interrupt did not wake");
   wait_cmd_a: assert property (wt && cmd.valid && cmd.cls == CMD_MEM_STAT
      |=> cmd_rsp.mode_err && !cmd_rsp.executed) else $error("status access not refused");
   mode_keep_a: assert property (run && !cmd.valid && !evs && !cpu_ev.wait_instr
      |=> $stable(mode_state)) else $error("run mode left without cause");
   // Main scenarios reached
   bgd_wake_c: cover property (wt && bgc);
   wait_in_c: cover property (run && cpu_ev.wait_instr);
   irq_wake_c: cover property (wt && cpu_ev.irq_req);
   boot_run_c: cover property (mode_state == ST_VECTOR);
endmodule : omc_mode_ctrl_sva
bind omc_mode_ctrl omc_mode_ctrl_sva u_sva (.aclk(aclk), .aresetn(aresetn), .cmd(cmd),
   .cmd_rsp(cmd_rsp), .cpu_ev(cpu_ev), .core(core), .vector_addr(vector_addr),
   .mode_state(mode_state));
`default_nettype wire

//--- omc_dbg_host.sv
// Behavioural debug host issuing commands on the command port
`timescale 1ns/1ns
`default_nettype none
module omc_dbg_host
   import omc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic [2:0]  mode_state,
   output var  omc_pkg::omc_cmd_t cmd
);
   import omc_pkg::*;
   initial cmd = '0;
   // One command pulse after a number of idle cycles
   task automatic issue(input omc_cmd_class_t cls, input int gap);
      repeat (gap) @(posedge aclk);
      @(posedge aclk);
      // In wait only BACKGROUND and status accesses go out
      if (mode_state != ST_WAIT || cls inside {CMD_BACKGROUND, CMD_MEM_STAT}) begin
         cmd <= '{valid: 1'b1, cls: cls};
      end
      @(posedge aclk);
      cmd <= '{valid: 1'b0, cls: omc_cmd_class_t'(~cls)}; // Idle class scrambled
   endtask : issue
endmodule : omc_dbg_host
`default_nettype wire

//--- omc_mode_ctrl_tb.sv
// Self-checking bench of the operating-mode control block
`timescale 1ns/1ns
`default_nettype none
module omc_mode_ctrl_tb;
   import omc_pkg::*;
   typedef struct packed {
      omc_cmd_class_t c;
      logic [2:0]     st;
      logic [3:0]     rsp;
   } omc_row_t;
   // Command, expected state, expected answer {done,executed,mode_err,ignored}
   localparam omc_row_t ROWS [15] = '{
      '{CMD_MEM, ST_HALT_TO_DEBUG_INSTRUCTION, 4'hc}, '{CMD_MEM_STAT, ST_HALT_TO_DEBUG_INSTRUCTION, 4'hc}, '{CMD_DBG_REG, ST_HALT_TO_DEBUG_INSTRUCTION, 4'hc},
      '{CMD_BACKGROUND, ST_HALT_TO_DEBUG_INSTRUCTION, 4'hc}, '{CMD_CPU_REG, ST_HALT_TO_DEBUG_INSTRUCTION, 4'hc},
      '{CMD_TRACE, ST_HALT_TO_DEBUG_INSTRUCTION, 4'hc}, '{CMD_RESUME, ST_RUN, 4'hc}, '{CMD_MEM, ST_RUN, 4'hc},
      '{CMD_MEM_STAT, ST_RUN, 4'hc}, '{CMD_DBG_REG, ST_RUN, 4'hc}, '{CMD_CPU_REG, ST_RUN, 4'h9},
      '{CMD_TRACE, ST_RUN, 4'h9}, '{CMD_RESUME, ST_RUN, 4'h9},
      '{CMD_BACKGROUND, ST_HALT_TO_DEBUG_INSTRUCTION, 4'hc}, '{CMD_RESUME, ST_RUN, 4'hc}};
   logic         aclk = 1'b0;
   logic         aresetn = 1'b0;
   logic         pin = 1'b0;
   logic [7:0]   awaddr = '0, araddr = '0;
   logic         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0]  wdata = '0, rd;
   logic [3:0]   wstrb = 4'hf;
   logic [1:0]   rs, bresp, rresp;
   logic         awready, wready, bvalid, arready, rvalid;
   logic [31:0]  rdata;
   omc_cmd_t     cmd;
   omc_cmd_rsp_t rsp;
   omc_cpu_ev_t  ev = '0;
   omc_core_t    core;
   logic [15:0]  vaddr;
   logic [2:0]   st;
   logic [7:0]   pull, slew;
   int           mismatches = 0, checked = 0, cyc = 0;
   omc_mode_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .mode_select_debug_pin(pin), .cmd(cmd), .cmd_rsp(rsp), .cpu_ev(ev), .core(core),
      .vector_addr(vaddr), .mode_state(st), .pad_pull_en(pull), .pad_slew_en(slew));
   omc_dbg_host u_host (.aclk(aclk), .mode_state(st), .cmd(cmd));
   // Clock and hang guard
   always #25 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches++;
         results();
      end
   end
   task automatic results();
      if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Bus write, held until each channel is taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bready && bvalid) begin
            bready <= 0; rs = bresp; break;
         end
      end
   endtask : axw
   // Bus read
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         if (rready && rvalid) begin
            rready <= 0; rd = rdata; rs = rresp; break;
         end
      end
   endtask : axr
   // One-cycle pulse on one CPU event bit
   task automatic pulse(input int b);
      @(posedge aclk);
      ev <= omc_cpu_ev_t'(6'h1 << b);
      @(posedge aclk);
      ev <= '0;
      #1;
   endtask : pulse
   task automatic do_reset(input logic p);
      @(posedge aclk);
      aresetn <= 0; pin <= p;
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      #1;
   endtask : do_reset
   // Main sequence
   initial begin
      do_reset(1'b0);
      chk(st, ST_HALT_TO_DEBUG_INSTRUCTION);
      chk({pull, slew}, 16'h0100);
      foreach (ROWS[i]) begin
         u_host.issue(ROWS[i].c, i % 2);
         #1;
         chk(rsp, ROWS[i].rsp);
         chk(st, ROWS[i].st);
         chk(core.cpu_suspend, ROWS[i].st == ST_HALT_TO_DEBUG_INSTRUCTION);
         chk(core.step, ROWS[i].c == CMD_TRACE && ROWS[i].rsp[2]);
      end
      for (int b = 3; b <= 5; b++) begin
         pulse(b);
         chk(st, ST_HALT_TO_DEBUG_INSTRUCTION);
         u_host.issue(CMD_RESUME, 0);
      end
      @(posedge aclk);
      ev <= omc_cpu_ev_t'(6'h1);
      u_host.issue(CMD_MEM_STAT, 0);
      #1;
      chk(rsp, 4'ha);
      ev <= '0;
      pulse(2);
      chk(st, ST_WAIT);
      chk({core.imask_clr, core.cpu_clk_en, core.sys_clk_en, core.reg_full}, 4'hb);
      u_host.issue(CMD_MEM_STAT, 1);
      #1;
      chk(rsp, 4'ha);
      pulse(1);
      chk({st, core.stack_start}, {ST_RUN, 1'b1});
      pulse(2);
      u_host.issue(CMD_BACKGROUND, 0);
      #1;
      chk({st, rsp}, {ST_HALT_TO_DEBUG_INSTRUCTION, 4'hc});
      axr(OFF_STATUS);
      chk(rd, 32'h0b);
      axr(OFF_CTRL);
      chk(rd, 32'h1);
      axr(8'h10);
      chk(rs, RESP_SLVERR);
      chk(rd, 32'h0);
      axw(OFF_PULL, 32'hff);
      axw(OFF_SLEW, 32'hff);
      axw(OFF_CTRL, 32'h3);
      repeat (2) @(posedge aclk);
      #1;
      chk({pull, slew}, 16'hf9f8);
      axw(OFF_CTRL, 32'h0);
      repeat (2) @(posedge aclk);
      #1;
      chk({pull, slew}, 16'hffff);
      axr(OFF_PULL);
      chk(rd, 32'hff);
      wstrb <= 4'he;
      axw(OFF_PULL, 32'h0);
      wstrb <= 4'hf;
      chk(rs, RESP_OKAY);
      axr(OFF_PULL);
      chk(rd, 32'hff);
      axw(8'h14, 32'h5);
      chk(rs, RESP_SLVERR);
      do_reset(1'b1);
      chk({st, core.vec_fetch, vaddr}, {ST_VECTOR, 1'b1, RESET_VECTOR_ADDR});
      @(posedge aclk);
      #1;
      chk({st, core.vec_fetch, core.cpu_clk_en}, {ST_RUN, 1'b0, 1'b1});
      pin <= 1'b0;
      repeat (6) @(posedge aclk);
      axr(OFF_STATUS);
      chk(rd, 32'h02);
      results();
   end
endmodule : omc_mode_ctrl_tb
`default_nettype wire
